// ===== hdl/pin_mux_pkg.sv
// constants, codes and carriers for the control pin function selector
package pin_mux_pkg;

  // pin counts and selection code width
  localparam int NUM_PINS = 5;
  localparam int NUM_IO_PINS = 4;
  localparam int SEL_W = 4;

  // timing: reference clock and clock output rates
  localparam int REF_CLK_MHZ = 200;
  localparam int CLK_FAST_MHZ = 48;
  // phase step that overflows a 32-bit accumulator at twice the fastest rate
  localparam logic [31:0] NCO_STEP =
    32'(((64'd1 << 32) * 64'(2 * CLK_FAST_MHZ)) / 64'(REF_CLK_MHZ));

  // activity led pulse: least on time, rounded up to whole cycles
  localparam int LED_ON_NS = 1000;
  localparam int LED_CNT_W = 16;
  localparam logic [LED_CNT_W-1:0] LED_ON_CYCLES =
    LED_CNT_W'((LED_ON_NS * REF_CLK_MHZ + 999) / 1000);

  // pin function codes as held in the configuration store
  typedef enum logic [SEL_W-1:0] {
    FN_LINE_DRV,
    FN_PWR_EN,
    FN_TX_LED,
    FN_RX_LED,
    FN_ANY_LED,
    FN_SUSPEND,
    FN_CLK_48,
    FN_CLK_24,
    FN_CLK_12,
    FN_CLK_6,
    FN_AUX_GPIO,
    FN_BB_WR,
    FN_BB_RD
  } pin_func_t;

  // factory defaults, pin 4 in the top nibble
  localparam logic [NUM_PINS*SEL_W-1:0] SEL_RESET =
    {FN_SUSPEND, FN_PWR_EN, FN_LINE_DRV, FN_RX_LED, FN_TX_LED};

  // apb register byte offsets
  localparam logic [7:0] SEL_OFS = 8'h00;
  localparam logic [7:0] CTRL_OFS = 8'h04;
  localparam logic [7:0] GPIO_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;

  // field positions
  localparam int CTRL_RELOAD_BIT = 0;
  localparam int GPIO_OUT_LSB = 0;
  localparam int GPIO_DIR_LSB = 4;
  localparam int STATUS_CONF_BIT = 0;
  localparam int STATUS_SUSP_BIT = 1;
  localparam int STATUS_TXB_BIT = 2;
  localparam int STATUS_REJ_BIT = 3;
  localparam int STATUS_GPIN_LSB = 4;

  // register reset values
  localparam logic [7:0] GPIO_RESET = 8'h00;

  // usb engine state
  typedef struct packed {
    logic configured;
    logic suspended;
  } usb_state_t;

  // serial side activity
  typedef struct packed {
    logic tx_busy;
    logic host_to_serial;
    logic serial_to_host;
  } serial_act_t;

  // bit-bang engine strobes, active low
  typedef struct packed {
    logic write_n;
    logic read_n;
  } bb_strobe_t;

endpackage

// ===== hdl/control_pin_function_select.sv
// control pin function selector with apb status and gpio registers
//
// The APB interface to the registers and the address map were decided locally.
module control_pin_function_select
  import pin_mux_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // configuration store
  input wire logic [NUM_PINS*SEL_W-1:0] cfg_sel_i,
  input wire logic cfg_reload_i,
  // device internals
  input wire usb_state_t usb_state_i,
  input wire serial_act_t serial_act_i,
  input wire bb_strobe_t bb_strobe_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // control pins
  input wire logic [NUM_IO_PINS-1:0] ctrl_pin_i,
  output logic [NUM_PINS-1:0] ctrl_pin_o,
  output logic [NUM_PINS-1:0] ctrl_pin_oe_n_o
);

  // one refused pin code is replaced by that pin's factory default
  function automatic logic [SEL_W-1:0] sanitize(input logic [SEL_W-1:0] code, input int idx);
    logic [SEL_W-1:0] res;
    res = code;
    if (code > FN_BB_RD) begin
      res = SEL_RESET[idx*SEL_W +: SEL_W];
    end else if (idx >= NUM_IO_PINS && (code == FN_AUX_GPIO || code == FN_BB_WR || code == FN_BB_RD)) begin
      res = SEL_RESET[idx*SEL_W +: SEL_W];
    end
    return res;
  endfunction

  // tells whether a code was refused for a pin
  function automatic logic refused(input logic [SEL_W-1:0] code, input int idx);
    return sanitize(code, idx) != code;
  endfunction

  // retriggerable led stretcher
  function automatic logic [LED_CNT_W-1:0] led_next(input logic [LED_CNT_W-1:0] cnt, input logic ev);
    logic [LED_CNT_W-1:0] res;
    res = cnt;
    if (ev) begin
      res = LED_ON_CYCLES;
    end else if (cnt != '0) begin
      res = cnt - LED_CNT_W'(1);
    end
    return res;
  endfunction

  logic [NUM_PINS*SEL_W-1:0] sel_ff;
  logic load_pend_ff;
  logic reject_ff;
  logic [31:0] nco_acc_ff;
  logic [3:0] div_cnt_ff;
  logic [LED_CNT_W-1:0] tx_led_cnt_ff;
  logic [LED_CNT_W-1:0] rx_led_cnt_ff;
  logic [LED_CNT_W-1:0] any_led_cnt_ff;
  logic [NUM_IO_PINS-1:0] gp_s1_ff;
  logic [NUM_IO_PINS-1:0] gp_s2_ff;
  logic [NUM_IO_PINS-1:0] gp_s3_ff;
  logic [NUM_IO_PINS-1:0] gp_in_ff;
  logic [7:0] gpio_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [NUM_PINS-1:0] pin_ff;
  logic [NUM_PINS-1:0] oe_n_ff;
  logic [NUM_PINS*SEL_W-1:0] nxt_sel;
  logic nxt_reject;
  logic [NUM_PINS-1:0] nxt_pin;
  logic [NUM_PINS-1:0] nxt_oe_n;
  logic [31:0] nxt_rdata;
  logic [32:0] nco_sum;
  logic addr_hit;
  logic apb_setup;
  logic apb_done;
  logic sw_reload;

  // apb phases; a write or read completes on the access edge with pready high
  assign apb_setup = psel_i && !penable_i;
  assign apb_done = psel_i && penable_i && pready_ff;
  assign sw_reload = apb_done && pwrite_i && paddr_i == CTRL_OFS && pwdata_i[CTRL_RELOAD_BIT];
  assign addr_hit = paddr_i == SEL_OFS || paddr_i == CTRL_OFS || paddr_i == GPIO_OFS || paddr_i == STATUS_OFS;

  // sanitised image of the store, pin by pin
  always_comb begin
    nxt_sel = '0;
    nxt_reject = 1'b0;
    for (int i = 0; i < NUM_PINS; i++) begin
      nxt_sel[i*SEL_W +: SEL_W] = sanitize(cfg_sel_i[i*SEL_W +: SEL_W], i);
      nxt_reject = nxt_reject | refused(cfg_sel_i[i*SEL_W +: SEL_W], i);
    end
  end

  // selection latch: defaults under reset, store copy once released or reloaded
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sel_ff <= SEL_RESET;
      load_pend_ff <= 1'b1;
      reject_ff <= 1'b0;
    end else if (ce_i) begin
      if (load_pend_ff || cfg_reload_i || sw_reload) begin
        sel_ff <= nxt_sel;
        reject_ff <= nxt_reject;
      end
      load_pend_ff <= 1'b0;
    end
  end

  // clock outputs: phase accumulator overflows at 96 MHz on average, so the
  // counter bits give exact average rates; edges jitter by one ref period
  assign nco_sum = {1'b0, nco_acc_ff} + {1'b0, NCO_STEP};
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      nco_acc_ff <= '0;
      div_cnt_ff <= '0;
    end else if (ce_i) begin
      if (usb_state_i.suspended) begin
        nco_acc_ff <= '0;
        div_cnt_ff <= '0;
      end else begin
        nco_acc_ff <= nco_sum[31:0];
        if (nco_sum[32]) begin
          div_cnt_ff <= div_cnt_ff + 4'h1;
        end
      end
    end
  end

  // activity led stretchers keep a single-cycle event visible to the eye
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_led_cnt_ff <= '0;
      rx_led_cnt_ff <= '0;
      any_led_cnt_ff <= '0;
    end else if (ce_i) begin
      tx_led_cnt_ff <= led_next(tx_led_cnt_ff, serial_act_i.host_to_serial);
      rx_led_cnt_ff <= led_next(rx_led_cnt_ff, serial_act_i.serial_to_host);
      any_led_cnt_ff <= led_next(any_led_cnt_ff,
        serial_act_i.host_to_serial | serial_act_i.serial_to_host);
    end
  end

  // pin input synchroniser; a change counts once the second and third stages agree
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gp_s1_ff <= '0;
      gp_s2_ff <= '0;
      gp_s3_ff <= '0;
      gp_in_ff <= '0;
    end else if (ce_i) begin
      gp_s1_ff <= ctrl_pin_i;
      gp_s2_ff <= gp_s1_ff;
      gp_s3_ff <= gp_s2_ff;
      for (int i = 0; i < NUM_IO_PINS; i++) begin
        if (gp_s2_ff[i] == gp_s3_ff[i]) begin
          gp_in_ff[i] <= gp_s3_ff[i];
        end
      end
    end
  end

  // gpio output value and direction, written over apb
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gpio_ff <= GPIO_RESET;
    end else if (ce_i) begin
      if (apb_done && pwrite_i && paddr_i == GPIO_OFS) begin
        gpio_ff <= pwdata_i[7:0];
      end
    end
  end

  // read data mux, sampled in the setup cycle
  always_comb begin
    nxt_rdata = '0;
    case (paddr_i)
      SEL_OFS: begin
        nxt_rdata[NUM_PINS*SEL_W-1:0] = sel_ff;
      end
      GPIO_OFS: begin
        nxt_rdata[7:0] = gpio_ff;
      end
      STATUS_OFS: begin
        nxt_rdata[STATUS_CONF_BIT] = usb_state_i.configured;
        nxt_rdata[STATUS_SUSP_BIT] = usb_state_i.suspended;
        nxt_rdata[STATUS_TXB_BIT] = serial_act_i.tx_busy;
        nxt_rdata[STATUS_REJ_BIT] = reject_ff;
        nxt_rdata[STATUS_GPIN_LSB +: NUM_IO_PINS] = gp_in_ff;
      end
      default: begin
        nxt_rdata = '0;
      end
    endcase
  end

  // apb answer: one wait-free access phase after every setup
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else if (ce_i) begin
      pready_ff <= apb_setup;
      if (apb_setup) begin
        pslverr_ff <= !addr_hit;
        prdata_ff <= nxt_rdata;
      end else if (apb_done) begin
        pslverr_ff <= 1'b0;
        prdata_ff <= '0;
      end
    end
  end

  // per-pin function mux; unused pins default to driven high
  always_comb begin
    nxt_pin = '1;
    nxt_oe_n = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      case (pin_func_t'(sel_ff[i*SEL_W +: SEL_W]))
        FN_LINE_DRV: begin
          nxt_pin[i] = serial_act_i.tx_busy;
        end
        FN_PWR_EN: begin
          nxt_pin[i] = !(usb_state_i.configured && !usb_state_i.suspended);
        end
        FN_TX_LED: begin
          nxt_pin[i] = tx_led_cnt_ff == '0;
        end
        FN_RX_LED: begin
          nxt_pin[i] = rx_led_cnt_ff == '0;
        end
        FN_ANY_LED: begin
          nxt_pin[i] = any_led_cnt_ff == '0;
        end
        FN_SUSPEND: begin
          nxt_pin[i] = !usb_state_i.suspended;
        end
        FN_CLK_48: begin
          nxt_pin[i] = div_cnt_ff[0];
        end
        FN_CLK_24: begin
          nxt_pin[i] = div_cnt_ff[1];
        end
        FN_CLK_12: begin
          nxt_pin[i] = div_cnt_ff[2];
        end
        FN_CLK_6: begin
          nxt_pin[i] = div_cnt_ff[3];
        end
        FN_AUX_GPIO: begin
          if (i < NUM_IO_PINS) begin
            nxt_pin[i] = gpio_ff[GPIO_OUT_LSB + i];
            nxt_oe_n[i] = !gpio_ff[GPIO_DIR_LSB + i];
          end
        end
        FN_BB_WR: begin
          nxt_pin[i] = bb_strobe_i.write_n;
        end
        FN_BB_RD: begin
          nxt_pin[i] = bb_strobe_i.read_n;
        end
        default: begin
          nxt_pin[i] = 1'b1;
        end
      endcase
    end
  end

  // pins leave straight from flops, so each function is one cycle late
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_ff <= '1;
      oe_n_ff <= '0;
    end else if (ce_i) begin
      pin_ff <= nxt_pin;
      oe_n_ff <= nxt_oe_n;
    end
  end

  assign ctrl_pin_o = pin_ff;
  assign ctrl_pin_oe_n_o = oe_n_ff;
  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;

endmodule

// ===== tb/pin_load.sv
// far side of the pins: pull-ups, and an outside driver for the io pins
module pin_load
  import pin_mux_pkg::*;
(
  input wire logic [NUM_PINS-1:0] dut_pin_i,
  input wire logic [NUM_PINS-1:0] dut_oe_n_i,
  input wire logic [NUM_IO_PINS-1:0] ext_en_i,
  input wire logic [NUM_IO_PINS-1:0] ext_val_i,
  output logic [NUM_IO_PINS-1:0] wire_lvl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // device wins while it drives; a released pin idles high through its pull-up
  assign wire_lvl_o = (~dut_oe_n_i[3:0] & dut_pin_i[3:0]) | (dut_oe_n_i[3:0] & (ext_val_i | ~ext_en_i));
endmodule

// ===== tb/control_pin_function_select_sva.sv
// assertions on the pins of the control pin selector
module control_pin_function_select_sva
  import pin_mux_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [NUM_PINS*SEL_W-1:0] cfg_sel_i,
  input wire logic cfg_reload_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire usb_state_t usb_state_i,
  input wire serial_act_t serial_act_i,
  input wire bb_strobe_t bb_strobe_i,
  input wire logic [NUM_PINS-1:0] ctrl_pin_o,
  input wire logic [NUM_PINS-1:0] ctrl_pin_oe_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NUM_PINS*SEL_W-1:0] sel_ff;
  logic [1:0] up_ff;
  logic ok;
  logic sw_rld;
  // a code the pin cannot carry falls back to that pin's factory default
  function automatic logic [SEL_W-1:0] keep(input logic [SEL_W-1:0] c, input int i);
    logic [SEL_W-1:0] r;
    r = c;
    if (c > FN_BB_RD || (i >= NUM_IO_PINS && c >= FN_AUX_GPIO)) begin
      r = SEL_RESET[i*SEL_W +: SEL_W];
    end
    return r;
  endfunction
  // software reload lands on the completing access edge of a ctrl write
  assign sw_rld = psel_i && penable_i && pready_o && pwrite_i && paddr_i == CTRL_OFS && pwdata_i[CTRL_RELOAD_BIT];
  // shadow of the latched selections, loaded on the first edge after reset
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sel_ff <= SEL_RESET;
    end else if (up_ff == 2'h0 || cfg_reload_i || sw_rld) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        sel_ff[i*SEL_W +: SEL_W] <= keep(cfg_sel_i[i*SEL_W +: SEL_W], i);
      end
    end
  end
  // settle count so that $past never looks back into reset
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      up_ff <= 2'h0;
    end else if (!ok) begin
      up_ff <= up_ff + 2'h1;
    end
  end
  assign ok = (up_ff == 2'h3);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_line_drv: assert property (ok && $past(sel_ff[3:0]) == FN_LINE_DRV |-> ctrl_pin_o[0] == $past(serial_act_i[2]))
    else $error("bad line drive");
  a_pwr_en: assert property (ok && $past(sel_ff[15:12]) == FN_PWR_EN |-> ctrl_pin_o[3] == !$past(usb_state_i == 2'h2))
    else $error("bad power enable");
  a_tx_led: assert property (ok && sel_ff[3:0] == FN_TX_LED && serial_act_i[1] |-> ##2 (!ctrl_pin_o[0]) [*4])
    else $error("bad tx led");
  a_rx_led: assert property (ok && sel_ff[7:4] == FN_RX_LED && serial_act_i[0] |-> ##2 (!ctrl_pin_o[1]) [*4])
    else $error("bad rx led");
  a_any_led: assert property (ok && sel_ff[3:0] == FN_ANY_LED && |serial_act_i[1:0] |-> ##2 !ctrl_pin_o[0])
    else $error("bad any led");
  a_sleep_pin: assert property (ok && $past(sel_ff[19:16]) == FN_SUSPEND |-> ctrl_pin_o[4] != $past(usb_state_i[0]))
    else $error("bad suspend pin");
  a_clock_stop: assert property (ok && $past(sel_ff[3:0]) inside {[FN_CLK_48:FN_CLK_6]} && $past(usb_state_i[0]) && $past(usb_state_i[0], 2)
    |-> !ctrl_pin_o[0]) else $error("clock runs in suspend");
  a_write_strobe: assert property (ok && $past(sel_ff[3:0]) == FN_BB_WR |-> ctrl_pin_o[0] == $past(bb_strobe_i[1]))
    else $error("bad write strobe");
  a_read_strobe: assert property (ok && $past(sel_ff[3:0]) == FN_BB_RD |-> ctrl_pin_o[0] == $past(bb_strobe_i[0]))
    else $error("bad read strobe");
  a_pin4_drives: assert property (!ctrl_pin_oe_n_o[4])
    else $error("pin 4 released");
endmodule
bind control_pin_function_select control_pin_function_select_sva control_pin_function_select_sva_i (.*);

// ===== tb/control_pin_function_select_bench.sv
// self-checking bench for the control pin selector
module control_pin_function_select_bench import pin_mux_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rst = 1'h1, rld = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0, prdy, perr, er;
  logic [19:0] sel = SEL_RESET;
  usb_state_t us = 2'h0;
  serial_act_t sa = 3'h0;
  bb_strobe_t bb = 2'h3;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic [3:0] pin_in, ext_en = 4'h0, ext_v = 4'h0;
  logic [4:0] pin, oe_n;
  int errors = 0, cmp_count = 0;
  always #2.5 clk = ~clk;
  control_pin_function_select control_pin_function_select_i (.ref_clk_i(clk), .rst_i(rst), .ce_i(1'h1),
    .cfg_sel_i(sel), .cfg_reload_i(rld), .usb_state_i(us), .serial_act_i(sa), .bb_strobe_i(bb), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
    .pslverr_o(perr), .ctrl_pin_i(pin_in), .ctrl_pin_o(pin), .ctrl_pin_oe_n_o(oe_n));
  pin_load pin_load_i (.dut_pin_i(pin), .dut_oe_n_i(oe_n), .ext_en_i(ext_en), .ext_val_i(ext_v), .wire_lvl_o(pin_in));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // outputs are read mid-cycle, clear of the edge that updates them
  task automatic mid;
    @(negedge clk);
  endtask
  // one apb transfer; the request holds until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    tick(1);
    psel <= 1'h1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    tick(1);
    pen <= 1'h1;
    // pready is judged at the rising edge, where the transfer completes
    do begin
      tick(1);
      k++;
    end while (prdy !== 1'h1 && k < 9);
    rd = prd;
    er = perr;
    psel <= 1'h0;
    pen <= 1'h0;
    errors += int'(k >= 9);
  endtask
  task automatic rdr(input logic [7:0] a);
    apb(1'h0, a, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic setp(input int p, input pin_func_t f);
    tick(1);
    sel[4*p+:4] <= f;
    rld <= 1'h1;
    tick(1);
    rld <= 1'h0;
  endtask
  // counts low cycles, or rising edges, of one pin
  task automatic cnt(input int b, input int n, input logic rise, output int c);
    logic p;
    c = 0;
    p = pin[b];
    repeat (n) begin
      mid;
      c += rise ? int'(pin[b] && !p) : int'(!pin[b]);
      p = pin[b];
    end
  endtask
  task automatic t_regs;
    rdr(SEL_OFS);
    chk(rd, 32'(SEL_RESET));
    wr(SEL_OFS, 32'h0);
    rdr(SEL_OFS);
    chk(rd, 32'(SEL_RESET));
    rdr(GPIO_OFS);
    chk(rd, 32'(GPIO_RESET));
    rdr(8'h10);
    chk({rd[30:0], er}, 32'h1);
    $display("regs done");
  endtask
  task automatic t_usb;
    mid;
    chk(pin[4:3], 2'h3);
    tick(1);
    us <= 2'h2;
    tick(2);
    mid;
    chk(pin[4:3], 2'h2);
    tick(1);
    us <= 2'h3;
    tick(2);
    mid;
    chk(pin[4:3], 2'h1);
    $display("usb done");
  endtask
  task automatic t_led;
    int c0, c1;
    tick(1);
    sa <= 3'h3;
    tick(1);
    sa <= 3'h0;
    fork
      cnt(0, 300, 1'h0, c0);
      cnt(1, 300, 1'h0, c1);
    join
    chk(c0, 32'(LED_ON_CYCLES));
    chk(c1, 32'(LED_ON_CYCLES));
    setp(0, FN_ANY_LED);
    sa <= 3'h1;
    tick(1);
    sa <= 3'h0;
    cnt(0, 300, 1'h0, c0);
    chk(c0, 32'(LED_ON_CYCLES));
    $display("led done");
  endtask
  task automatic t_clk;
    int c, e;
    for (int k = 0; k < 4; k++) begin
      setp(0, pin_func_t'(FN_CLK_48 + k));
      us <= 2'h2;
      tick(20);
      cnt(0, 1000, 1'h1, c);
      e = (CLK_FAST_MHZ * 1000 / REF_CLK_MHZ) >> k;
      chk(32'(c >= e - 1 && c <= e + 1), 32'h1);
    end
    tick(1);
    us <= 2'h3;
    tick(3);
    cnt(0, 100, 1'h0, c);
    chk(c, 32'd100);
    $display("clk done");
  endtask
  task automatic t_pins;
    setp(0, FN_BB_WR);
    bb <= 2'h1;
    tick(2);
    mid;
    chk(pin[0], 1'h0);
    setp(0, FN_BB_RD);
    tick(2);
    mid;
    chk(pin[0], 1'h1);
    tick(1);
    bb <= 2'h2;
    tick(2);
    mid;
    chk(pin[0], 1'h0);
    setp(0, FN_LINE_DRV);
    sa <= 3'h4;
    tick(2);
    mid;
    chk(pin[0], 1'h1);
    tick(1);
    sa <= 3'h0;
    $display("pins done");
  endtask
  task automatic t_gpio;
    setp(1, FN_AUX_GPIO);
    wr(GPIO_OFS, 32'h22);
    tick(2);
    mid;
    chk({oe_n[1], pin[1]}, 2'h1);
    wr(GPIO_OFS, 32'h0);
    ext_en <= 4'h2;
    tick(6);
    rdr(STATUS_OFS);
    chk(rd[5], 1'h0);
    mid;
    chk(oe_n[1], 1'h1);
    $display("gpio done");
  endtask
  task automatic t_refuse;
    logic [19:0] old;
    old = sel;
    tick(1);
    sel <= 20'hAFFFF;
    ext_en <= 4'h0;
    tick(3);
    rdr(SEL_OFS);
    chk(rd, 32'(old));
    wr(CTRL_OFS, 32'h1);
    us <= 2'h2;
    sa <= 3'h4;
    tick(3);
    mid;
    chk({oe_n, pin}, 10'h017);
    rdr(STATUS_OFS);
    chk(rd[3], 1'h1);
    sa <= 3'h0;
    $display("refuse done");
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    tick(3);
    rst <= 1'h0;
    t_regs;
    t_usb;
    t_led;
    t_clk;
    t_pins;
    t_gpio;
    t_refuse;
    end_sim;
  end
  // watchdog well beyond the roughly 5000 cycles the tests need
  initial begin
    #200000;
    errors++;
    end_sim;
  end
endmodule
